// *** bench/spf_ctrl_assertions.sv ***
// Concurrent checks on the ports of the self-program flash control block.
// Assumes it is bound into spf_ctrl and shares its section and fuse parameters.
`timescale 1ns/1ns
module spf_ctrl_assertions
#(
    parameter logic [15:0] BOOT_START = 16'h3800,
    parameter logic [7:0]  FUSE_VALUE = 8'hff
)
(
    // Clock, reset and bus
    input wire logic              CLK,
    input wire logic              RESET,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [11:0]       PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    // Core and flash side
    input wire spf_pkg::spf_req_t REQ,
    input wire logic [7:0]        LOAD_DATA,
    input wire logic              LOAD_SPECIAL,
    input wire logic              STORE_BLOCKED,
    input wire logic              CORE_STALL,
    input wire logic              FLASH_DONE,
    input wire logic              FLASH_ERASE,
    input wire logic              FLASH_WRITE,
    input wire logic              BUF_FILL
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic       csr_wr;
    logic [2:0] age;
    assign csr_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == spf_pkg::CSR_ADDR;
    // Cycles since the last control write, saturating
    always_ff @(posedge CLK or posedge RESET)
        if (RESET)
            age <= 3'h0;
        else if (csr_wr)
            age <= 3'h0;
        else if (age != 3'h7)
            age <= age + 3'h1;
    sequence cmd(logic [4:0] c);
        csr_wr && PWDATA[4:0] == c;
    endsequence
    fill_start_a: assert property (cmd(spf_pkg::CMD_FILL) ##[1:4] REQ.store |=> BUF_FILL)
        else $error("armed fill store gave no buffer strobe");
    erase_start_a: assert property (cmd(spf_pkg::CMD_ERASE) ##[1:4] (REQ.store && REQ.pointer < BOOT_START)
        |=> FLASH_ERASE) else $error("armed erase store gave no erase strobe");
    write_start_a: assert property (cmd(spf_pkg::CMD_WRITE) ##[1:4] REQ.store |=> FLASH_WRITE)
        else $error("armed write store gave no write strobe");
    fuse_read_a: assert property (cmd(spf_pkg::CMD_LOCKSET) ##[1:3] (REQ.load && REQ.pointer[0])
        |=> LOAD_SPECIAL && LOAD_DATA == FUSE_VALUE) else $error("fuse readback wrong");
    stall_hold_a: assert property (CORE_STALL && !FLASH_DONE |=> CORE_STALL)
        else $error("core stall dropped before flash done");
    rsvd_zero_a: assert property (PSEL && PENABLE && PREADY && !PWRITE && PADDR == spf_pkg::CSR_ADDR
        |-> PRDATA[5] == 1'b0) else $error("reserved control bit read as one");
    idle_store_a: assert property (age == 3'h7 && REQ.store |=> !(BUF_FILL || FLASH_ERASE || FLASH_WRITE))
        else $error("unarmed store reached the flash");
    blocked_store_a: assert property (STORE_BLOCKED |-> !FLASH_ERASE && !FLASH_WRITE)
        else $error("blocked store still reached the flash");
endmodule
bind spf_ctrl spf_ctrl_assertions #(.BOOT_START(BOOT_START), .FUSE_VALUE(FUSE_VALUE)) chk
(
    .CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .REQ, .LOAD_DATA,
    .LOAD_SPECIAL, .STORE_BLOCKED, .CORE_STALL, .FLASH_DONE, .FLASH_ERASE, .FLASH_WRITE, .BUF_FILL
);

// *** bench/spf_flash_model.sv ***
// Behavioural flash array: answers each erase or write strobe with a done pulse.
// Assumes strobes on clk; delay (at least 1) sets a prompt or slow answer.
`timescale 1ns/1ns
module spf_flash_model
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Strobes and answer
    input wire logic       erase,
    input wire logic       write,
    input wire logic [7:0] delay,
    output logic           done
);
    logic [7:0] left;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            left <= 8'h00;
        else if (erase || write)
            left <= delay;
        else if (left != 8'h00)
            left <= left - 8'h01;
    assign done = left == 8'h01;
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the self-program flash control block.
// Assumes the flash model on the far side and APB access to the control register.
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] CSR  = spf_pkg::CSR_ADDR;
    localparam logic [15:0] BOOT = 16'h3800;
    logic              CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, GLOBAL_IRQ_EN, CHIP_ERASE;
    logic              LOAD_SPECIAL, LOAD_BLOCKED, STORE_BLOCKED, CORE_STALL, IRQ_SUPPRESS, READY_IRQ;
    logic              FLASH_DONE, FLASH_ERASE, FLASH_WRITE, BUF_FILL, BUF_CLEAR, err;
    logic [11:0]       PADDR;
    logic [31:0]       PWDATA, PRDATA, rd;
    logic [15:0]       FLASH_ADDR, FLASH_DATA, dat;
    logic [7:0]        LOAD_DATA, dly;
    spf_pkg::spf_req_t REQ;
    int                bad_count, n_tests, seed, i;
    spf_ctrl #(.BOOT_START(BOOT), .FUSE_VALUE(8'h5a)) uut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .REQ, .GLOBAL_IRQ_EN, .VECTORS_IN_BOOT(1'b0), .CHIP_ERASE,
        .LOAD_DATA, .LOAD_SPECIAL, .LOAD_BLOCKED, .STORE_BLOCKED, .CORE_STALL, .IRQ_SUPPRESS, .READY_IRQ,
        .FLASH_DONE, .FLASH_ERASE, .FLASH_WRITE, .BUF_FILL, .BUF_CLEAR, .FLASH_ADDR, .FLASH_DATA);
    spf_flash_model far (.clk(CLK), .rst(RESET), .erase(FLASH_ERASE), .write(FLASH_WRITE), .delay(dly),
        .done(FLASH_DONE));
    always #5 CLK = ~CLK;
    // Lock bits can only be programmed towards zero
    function automatic logic [7:0] lock_after(input logic [7:0] old, input logic [7:0] req);
        return old & req;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Starts after a rising edge; answer sampled mid-cycle, released after the access edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'h1;
        @(negedge CLK);
        while (PREADY !== 1'h1)
        begin
            @(posedge CLK);
            @(negedge CLK);
        end
        rd = PRDATA;
        err = PSLVERR;
        @(posedge CLK);
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    // One store (s=1) or load (s=0) strobe; returns mid-cycle with the answer settled
    task automatic core(input logic s, input logic [15:0] p, input logic [15:0] d);
        @(posedge CLK);
        REQ <= '{s, !s, p, d, 1'b0};
        @(posedge CLK);
        REQ <= '0;
        @(negedge CLK);
    endtask
    task automatic settle();
        do
            apb(1'h0, CSR, 32'h0);
        while (rd[0] !== 1'h0);
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        bad_count++;
        test_done();
    end
    initial
    begin
        CLK = 1'h0;
        RESET = 1'h1;
        {PSEL, PENABLE, PWRITE, GLOBAL_IRQ_EN, CHIP_ERASE} = 5'h0;
        PADDR = 12'h0;
        PWDATA = 32'h0;
        REQ = '0;
        seed = 53;
        dly = 8'h02;
        repeat (2) @(posedge CLK);
        RESET <= 1'h0;
        @(posedge CLK);
        apb(1'h0, spf_pkg::LOCK_ADDR, 32'h0);
        chk(rd[7:0], spf_pkg::LOCK_RESET);
        apb(1'h0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'h1, CSR, 32'h27);
        apb(1'h0, CSR, 32'h0);
        chk(rd, 32'h0);
        apb(1'h1, CSR, 32'h80);
        GLOBAL_IRQ_EN <= 1'h1;
        repeat (3) @(negedge CLK);
        chk(READY_IRQ, 32'h1);
        @(posedge CLK);
        GLOBAL_IRQ_EN <= 1'h0;
        repeat (3) @(negedge CLK);
        chk(READY_IRQ, 32'h0);
        apb(1'h1, CSR, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            dat = 16'($random(seed));
            apb(1'h1, CSR, 32'(spf_pkg::CMD_FILL));
            core(1'h1, dat, dat);
            chk({BUF_FILL, FLASH_ADDR[15:1], FLASH_DATA}, {1'h1, dat[15:1], dat});
        end
        apb(1'h1, CSR, 32'(spf_pkg::CMD_FILL));
        repeat (5) @(posedge CLK);
        apb(1'h0, CSR, 32'h0);
        chk(rd, 32'h0);
        dly <= 8'h20 + {3'h0, 5'($random(seed))};
        apb(1'h1, CSR, 32'(spf_pkg::CMD_ERASE));
        core(1'h1, 16'h0100, 16'h0);
        chk(FLASH_ERASE, 32'h1);
        apb(1'h0, CSR, 32'h0);
        chk(rd[7:0], 8'h43);
        core(1'h0, 16'h0100, 16'h0);
        chk(LOAD_BLOCKED, 32'h1);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_REENABLE));
        settle();
        chk(rd[7:0], 8'h40);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_REENABLE));
        core(1'h1, 16'h0, 16'h0);
        apb(1'h0, CSR, 32'h0);
        chk(rd[7:0], 8'h00);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_ERASE));
        core(1'h1, 16'h0200, 16'h0);
        settle();
        apb(1'h1, CSR, 32'(spf_pkg::CMD_FILL));
        core(1'h1, 16'h0002, 16'h0005);
        apb(1'h0, CSR, 32'h0);
        chk(rd[7:0], 8'h00);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_REENABLE));
        core(1'h1, 16'h0, 16'h0);
        chk(BUF_CLEAR, 32'h1);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_WRITE));
        core(1'h1, BOOT, 16'h0);
        chk(FLASH_WRITE, 32'h1);
        @(negedge CLK);
        chk(CORE_STALL, 32'h1);
        while (CORE_STALL !== 1'h0)
            @(negedge CLK);
        settle();
        chk(rd[7:0], 8'h00);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_LOCKSET));
        core(1'h1, 16'hffff, 16'h12ef);
        apb(1'h0, spf_pkg::LOCK_ADDR, 32'h0);
        chk(rd[7:0], lock_after(8'hff, 8'hef));
        chk(IRQ_SUPPRESS, 32'h0);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_ERASE));
        core(1'h1, BOOT, 16'h0);
        chk({STORE_BLOCKED, FLASH_ERASE}, 32'h2);
        apb(1'h1, CSR, 32'(spf_pkg::CMD_LOCKSET));
        core(1'h1, 16'h0, 16'h00ff);
        apb(1'h0, spf_pkg::LOCK_ADDR, 32'h0);
        chk(rd[7:0], lock_after(8'hef, 8'hff));
        for (i = 0; i < 2; i++)
        begin
            // Let the previous arming window run out first
            repeat (4) @(posedge CLK);
            apb(1'h1, CSR, 32'(spf_pkg::CMD_LOCKSET));
            core(1'h0, 16'(i), 16'h0);
            chk({LOAD_SPECIAL, LOAD_DATA}, {23'h0, 1'h1, (i == 1) ? 8'h5a : 8'hef});
        end
        repeat (5) @(posedge CLK);
        apb(1'h0, CSR, 32'h0);
        chk(rd[7:0], 8'h00);
        CHIP_ERASE <= 1'h1;
        @(posedge CLK);
        CHIP_ERASE <= 1'h0;
        @(posedge CLK);
        apb(1'h0, spf_pkg::LOCK_ADDR, 32'h0);
        chk(rd[7:0], 8'hff);
        test_done();
    end
endmodule

// *** inc/spf_pkg.sv ***
// Package for the self-program flash control block: register map, fields, timing.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package spf_pkg;
    // Register map
    localparam logic [7:0]  CSR_INDEX       = 8'h37;
    localparam logic [11:0] CSR_ADDR        = {2'h0, CSR_INDEX, 2'h0};
    localparam logic [11:0] LOCK_ADDR       = 12'h100;
    localparam logic [11:0] FUSE_ADDR       = 12'h104;
    localparam logic [11:0] STAT_ADDR       = 12'h108;
    localparam logic [7:0]  CSR_RESET       = 8'h00;
    localparam logic [7:0]  LOCK_RESET      = 8'hff;
    // Control/status field positions
    localparam int BIT_ENABLE   = 0;
    localparam int BIT_ERASE    = 1;
    localparam int BIT_WRITE    = 2;
    localparam int BIT_LOCKSET  = 3;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_RSVD     = 5;
    localparam int BIT_BUSY     = 6;
    localparam int BIT_IRQEN    = 7;
    // Legal low-five-bit patterns
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCKSET  = 5'h09;
    localparam logic [4:0] CMD_WRITE    = 5'h05;
    localparam logic [4:0] CMD_ERASE    = 5'h03;
    localparam logic [4:0] CMD_FILL     = 5'h01;
    // Lock byte fields
    localparam int LOCK_MEM_LO  = 0;
    localparam int LOCK_APP_LO  = 2;
    localparam int LOCK_BOOT_LO = 4;
    localparam logic [1:0] LOCK_NONE  = 2'h3;
    localparam logic [1:0] LOCK_NOWR  = 2'h2;
    localparam logic [1:0] LOCK_ALL   = 2'h0;
    localparam logic [1:0] LOCK_NORD  = 2'h1;
    // Timing
    localparam int ARM_CYCLES  = 4;
    localparam int READ_WINDOW = 3;
    localparam logic [2:0] ARM_COUNT  = 3'(ARM_CYCLES);
    localparam logic [2:0] READ_COUNT = 3'(ARM_CYCLES - READ_WINDOW);

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_ARMED  = 3'b001,
        ST_BUSY   = 3'b010,
        ST_LOCKWR = 3'b011
    } spf_state_t;

    // Store/load request from the core
    typedef struct packed
    {
        logic        store;
        logic        load;
        logic [15:0] pointer;
        logic [15:0] data;
        logic        from_boot;
    } spf_req_t;
endpackage

// *** rtl/spf_ctrl.sv ***
// Self-program flash control: control/status register, arming window, section busy,
// lock-bit protection. Assumes the core issues one-cycle store/load strobes on CLK and
// the flash array reports completion by a one-cycle done pulse on CLK.
//
// Contract
// - Ready interrupt requested when enable bit set, global flag set, self-program enable zero.
// - Erase or write to concurrent section sets busy; busy blocks that section.
// - Writing re-enable after the operation finished clears busy.
// - Starting a page buffer load clears busy.
// - Reserved control bit reads zero.
// - Re-enable with enable, then store within four cycles, reopens the section.
// - Re-enable refused while erase or write still runs.
// - Re-enable during buffer load aborts load and discards buffered data.
// - Lock-set with enable, store within four cycles programs lock bits from low data.
// - Lock-set bit clears on completion or four cycles without store.
// - Load within three cycles of lock-set returns lock or fuse bits by pointer bit 0.
// - Page-write armed store writes buffer to high-pointer page; clears on done or timeout.
// - Core stalled for whole erase or write to stalling section.
// - Page-erase armed store erases high-pointer page; clears on done or timeout.
// - Enable alone: store puts data pair into buffer word at pointer, bit 0 ignored.
// - Enable clears after store or four idle cycles; stays high during erase/write (code clears it at once if that store is in the fourth armed cycle).
// - Only patterns 10001, 01001, 00101, 00011, 00001 take effect.
// - Lock bits only go to zero; only chip erase returns them to one (code also reloads them to one on RESET).
// - Memory lock: 11 none, 10 no programming, 00 also no verification (code only reports a memory lock in status bit 1).
// - Application lock pair blocks writes, boot reads of application, or both.
// - Boot lock pair blocks writes, application reads of boot, or both.
// - In read-blocking modes interrupts suppressed while running from protected section.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module spf_ctrl
#(
    parameter logic [15:0] BOOT_START = 16'h3800,
    parameter logic [7:0]  FUSE_VALUE = 8'hff,
    parameter int          PAGE_LSB   = 7
)
(
    // Clock and reset
    input  wire logic                 CLK,
    input  wire logic                 RESET,
    // APB slave
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    // Core side
    input  wire spf_pkg::spf_req_t    REQ,
    input  wire logic                 GLOBAL_IRQ_EN,
    input  wire logic                 VECTORS_IN_BOOT,
    input  wire logic                 CHIP_ERASE,
    output logic      [7:0]           LOAD_DATA,
    output logic                      LOAD_SPECIAL,
    output logic                      LOAD_BLOCKED,
    output logic                      STORE_BLOCKED,
    output logic                      CORE_STALL,
    output logic                      IRQ_SUPPRESS,
    output logic                      READY_IRQ,
    // Flash array side
    input  wire logic                 FLASH_DONE,
    output logic                      FLASH_ERASE,
    output logic                      FLASH_WRITE,
    output logic                      BUF_FILL,
    output logic                      BUF_CLEAR,
    output logic      [15:0]          FLASH_ADDR,
    output logic      [15:0]          FLASH_DATA
);
    spf_pkg::spf_state_t state;
    logic [7:0] csr;
    logic [7:0] lock_bits;
    logic [2:0] arm_cnt;
    logic       stalling_read_section_op;
    logic       filling;

    wire logic wr_acc = PSEL && PENABLE && PWRITE;
    wire logic rd_acc = PSEL && PENABLE && !PWRITE;
    wire logic [4:0] cmd = PWDATA[4:0];
    wire logic csr_wr = wr_acc && PADDR == spf_pkg::CSR_ADDR;
    wire logic cmd_ok = csr_wr && (cmd == spf_pkg::CMD_REENABLE || cmd == spf_pkg::CMD_LOCKSET
                        || cmd == spf_pkg::CMD_WRITE || cmd == spf_pkg::CMD_ERASE
                        || cmd == spf_pkg::CMD_FILL);
    wire logic armed = state == spf_pkg::ST_ARMED;
    wire logic store = armed && REQ.store;
    wire logic ptr_boot = REQ.pointer[15:1] >= BOOT_START[15:1];
    wire logic [1:0] app_lk  = lock_bits[spf_pkg::LOCK_APP_LO +: 2];
    wire logic [1:0] boot_lk = lock_bits[spf_pkg::LOCK_BOOT_LO +: 2];
    wire logic app_wr_blk  = app_lk == spf_pkg::LOCK_NOWR || app_lk == spf_pkg::LOCK_ALL;
    wire logic boot_wr_blk = boot_lk == spf_pkg::LOCK_NOWR || boot_lk == spf_pkg::LOCK_ALL;
    wire logic app_rd_blk  = app_lk == spf_pkg::LOCK_ALL || app_lk == spf_pkg::LOCK_NORD;
    wire logic boot_rd_blk = boot_lk == spf_pkg::LOCK_ALL || boot_lk == spf_pkg::LOCK_NORD;
    wire logic mem_locked  = lock_bits[spf_pkg::LOCK_MEM_LO +: 2] != spf_pkg::LOCK_NONE;
    wire logic wr_blk = ptr_boot ? boot_wr_blk : app_wr_blk;
    wire logic is_erase = csr[spf_pkg::BIT_ERASE];
    wire logic is_write = csr[spf_pkg::BIT_WRITE];
    wire logic is_lock  = csr[spf_pkg::BIT_LOCKSET];
    wire logic is_reen  = csr[spf_pkg::BIT_REENABLE];
    wire logic is_fill  = !(is_erase || is_write || is_lock || is_reen);
    wire logic page_go  = store && (is_erase || is_write) && !wr_blk;

    // Arming state machine and countdown
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state   <= spf_pkg::ST_IDLE;
            arm_cnt <= 3'h0;
        end
        else
        begin
            unique case (state)
                spf_pkg::ST_IDLE:
                begin
                    if (cmd_ok && !(cmd == spf_pkg::CMD_REENABLE && csr[spf_pkg::BIT_ENABLE]))
                    begin
                        state   <= spf_pkg::ST_ARMED;
                        arm_cnt <= spf_pkg::ARM_COUNT;
                    end
                end
                spf_pkg::ST_ARMED:
                begin
                    if (page_go)
                        state <= spf_pkg::ST_BUSY;
                    else if (store && is_lock)
                        state <= spf_pkg::ST_LOCKWR;
                    else if (store || arm_cnt == 3'h1)
                        state <= spf_pkg::ST_IDLE;
                    arm_cnt <= arm_cnt - 3'h1;
                end
                spf_pkg::ST_BUSY:
                begin
                    if (FLASH_DONE)
                        state <= spf_pkg::ST_IDLE;
                end
                spf_pkg::ST_LOCKWR:
                    state <= spf_pkg::ST_IDLE;
                default:
                    state <= spf_pkg::ST_IDLE;
            endcase
        end
    end

    // Control/status register
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            csr <= spf_pkg::CSR_RESET;
        else
        begin
            if (csr_wr)
                csr[spf_pkg::BIT_IRQEN] <= PWDATA[spf_pkg::BIT_IRQEN];
            if (state == spf_pkg::ST_IDLE && cmd_ok
                && !(cmd == spf_pkg::CMD_REENABLE && csr[spf_pkg::BIT_ENABLE]))
                csr[4:0] <= cmd;
            else if ((armed && (arm_cnt == 3'h1 || (store && !page_go && !is_lock)))
                     || state == spf_pkg::ST_LOCKWR
                     || (state == spf_pkg::ST_BUSY && FLASH_DONE))
                csr[4:0] <= 5'h00;
            if (page_go && !ptr_boot)
                csr[spf_pkg::BIT_BUSY] <= 1'b1;
            else if ((store && is_reen) || (store && is_fill))
                csr[spf_pkg::BIT_BUSY] <= 1'b0;
            csr[spf_pkg::BIT_RSVD] <= 1'b0;
        end
    end

    // Stalling-section operation tracking
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            stalling_read_section_op <= 1'b0;
        else if (page_go)
            stalling_read_section_op <= ptr_boot;
        else if (state == spf_pkg::ST_BUSY && FLASH_DONE)
            stalling_read_section_op <= 1'b0;
    end

    // Buffer fill in progress
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            filling <= 1'b0;
        else if (store && is_fill)
            filling <= 1'b1;
        else if ((store && is_reen) || page_go)
            filling <= 1'b0;
    end

    // Lock bits: program to zero only, chip erase restores
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            lock_bits <= spf_pkg::LOCK_RESET;
        else if (CHIP_ERASE)
            lock_bits <= spf_pkg::LOCK_RESET;
        else if (store && is_lock)
            lock_bits <= lock_bits & REQ.data[7:0];
    end

    // Flash array commands
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            FLASH_ERASE <= 1'b0;
            FLASH_WRITE <= 1'b0;
            BUF_FILL    <= 1'b0;
            BUF_CLEAR   <= 1'b0;
            FLASH_ADDR  <= 16'h0000;
            FLASH_DATA  <= 16'h0000;
        end
        else
        begin
            FLASH_ERASE <= page_go && is_erase;
            FLASH_WRITE <= page_go && is_write;
            BUF_FILL    <= store && is_fill;
            BUF_CLEAR   <= store && is_reen && filling;
            if (page_go)
                FLASH_ADDR <= {REQ.pointer[15:PAGE_LSB], PAGE_LSB'(0)};
            else if (store && is_fill)
                FLASH_ADDR <= {REQ.pointer[15:1], 1'b0};
            if (store && is_fill)
                FLASH_DATA <= REQ.data;
        end
    end

    // Core side status and load path
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            LOAD_DATA     <= 8'h00;
            LOAD_SPECIAL  <= 1'b0;
            LOAD_BLOCKED  <= 1'b0;
            STORE_BLOCKED <= 1'b0;
            CORE_STALL    <= 1'b0;
            IRQ_SUPPRESS  <= 1'b0;
            READY_IRQ     <= 1'b0;
        end
        else
        begin
            LOAD_SPECIAL <= REQ.load && armed && is_lock && arm_cnt > spf_pkg::READ_COUNT;
            LOAD_DATA    <= REQ.pointer[0] ? FUSE_VALUE : lock_bits;
            LOAD_BLOCKED <= REQ.load && ((!ptr_boot && csr[spf_pkg::BIT_BUSY])
                            || (REQ.from_boot && !ptr_boot && app_rd_blk)
                            || (!REQ.from_boot && ptr_boot && boot_rd_blk));
            STORE_BLOCKED <= store && (is_erase || is_write) && wr_blk;
            CORE_STALL    <= (page_go && ptr_boot) || (stalling_read_section_op && !(state == spf_pkg::ST_BUSY && FLASH_DONE));
            IRQ_SUPPRESS  <= (REQ.from_boot && VECTORS_IN_BOOT == 1'b0 && boot_rd_blk)
                             || (!REQ.from_boot && VECTORS_IN_BOOT && app_rd_blk);
            READY_IRQ     <= csr[spf_pkg::BIT_IRQEN] && GLOBAL_IRQ_EN && !csr[spf_pkg::BIT_ENABLE];
        end
    end

    // APB slave, zero wait states
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE)
            begin
                unique case (PADDR)
                    spf_pkg::CSR_ADDR:  PRDATA <= {24'h0, csr & ~(8'h1 << spf_pkg::BIT_RSVD)};
                    spf_pkg::LOCK_ADDR: PRDATA <= {24'h0, lock_bits};
                    spf_pkg::FUSE_ADDR: PRDATA <= {24'h0, FUSE_VALUE};
                    spf_pkg::STAT_ADDR: PRDATA <= {28'h0, filling, stalling_read_section_op, mem_locked, armed};
                    default:
                    begin
                        PRDATA  <= 32'h0000_0000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    wire logic unused_ok = rd_acc;
endmodule
